// ===== rtl/ptcb_top.sv
// Contract
// - command is two 32-bit words written by processor or DMA.
// - nonzero step count decrements and steps; zero count re-examines the buffer.
// - buffer evaluation copies period to next width, control to private copy.
// - no valid new-command flag means the generator goes idle.
// - accepted command clears the control word to zero, signalling empty buffer.
// - decode continues from the private copy, immune to new writes.
// - control bits 31:28 flag, 27:24 direction, 23:22 acceleration, low bits count.
// - direction 0001 forward, 1111 reverse, 0000 pure delay.
// - step count field loads step counter; direction goes to direction holder.
// - acceleration 11 decelerate, 10 accelerate, 00 constant; selects seeding path.
// - after seeding, return to step-count check which now starts first step.
// - next width is previous width minus (accelerate) or plus (decelerate) an integer quotient.
// - division numerator is four times previous width.
// - quotient rounded by adding one and halving before applying.
// - acceleration denominator starts at 5, grows by 4 each step.
// - deceleration denominator starts at 4m-5, shrinks by 4 each step.
// - command-accepted interrupt or DMA request is not implemented.
// - starts in reset; host writes 0x40000000 to state word to reach idle.
// - idle holds step outputs at last levels, no stray pulses.
// - idle and active change on their own; writing a command starts a train.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps

module ptcb_top #(
  parameter int CNT_W = ptcb_pkg::CNT_W
) (
  // clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // step execution side
  input  wire logic        step_done_i,
  output logic             step_start_o,
  output ptcb_pkg::ptcb_pulse_s pulse_o,
  output logic [1:0]       gen_state_o
);

  typedef enum logic [2:0] {
    S_RESET,
    S_IDLE,
    S_CHECK,
    S_EVAL,
    S_DIV,
    S_WAIT
  } ptcb_fsm_e;

  ptcb_fsm_e             fsm_q;
  logic [31:0]           period_q;
  logic [31:0]           ctrl_q;
  ptcb_pkg::ptcb_ctrl_s  work_q;
  logic [CNT_W-1:0]      steps_q;
  logic [31:0]           pw_q;
  logic [3:0]            dir_q;
  logic [1:0]            acc_q;
  logic signed [31:0]    den_q;
  logic [31:0]           quo_q;
  logic [31:0]           rem_q;
  logic [31:0]           num_q;
  logic [5:0]            div_cnt_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic                  step_start_q;
  ptcb_pkg::ptcb_pulse_s pulse_q;
  ptcb_pkg::ptcb_gen_e   gen_q;

  logic                  acc_phase;
  logic                  wr_en;
  logic                  wr_ctrl;
  logic                  hw_clr;
  logic                  mapped;
  logic [31:0]           rd_mux;
  logic [32:0]           rem_sh;
  logic [31:0]           delta;

  assign acc_phase = psel_i && penable_i;
  // writes land only at the edge where pready is seen high
  assign wr_en     = acc_phase && pwrite_i && pready_q && !pslverr_q;
  assign wr_ctrl   = wr_en && (paddr_i == ptcb_pkg::OFS_CTRL);

  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a == ptcb_pkg::OFS_PERIOD) begin
      ok = 1'b1;
    end else if (a == ptcb_pkg::OFS_CTRL) begin
      ok = 1'b1;
    end else if (a == ptcb_pkg::OFS_STATE) begin
      ok = 1'b1;
    end else if (a == ptcb_pkg::OFS_STEPS) begin
      ok = 1'b1;
    end else if (a == ptcb_pkg::OFS_PWIDTH) begin
      ok = 1'b1;
    end else if (a == ptcb_pkg::OFS_DIR) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic logic [31:0] state_word(input ptcb_pkg::ptcb_gen_e g);
    logic [31:0] w;
    w = ptcb_pkg::ST_W_RST;
    case (g)
      ptcb_pkg::GEN_IDLE:   w = ptcb_pkg::ST_W_IDLE;
      ptcb_pkg::GEN_ACTIVE: w = ptcb_pkg::ST_W_ACT;
      default:              w = ptcb_pkg::ST_W_RST;
    endcase
    return w;
  endfunction

  // seed goes negative for counts below 2; the divider then leaves the width unchanged
  function automatic logic [31:0] dec_seed(input logic [CNT_W-1:0] m);
    logic [31:0] wide;
    wide = 32'(m);
    return (wide << 2) - ptcb_pkg::DEN_DEC_OFS;
  endfunction

  assign mapped = addr_ok(paddr_i);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr_i == ptcb_pkg::OFS_PERIOD) begin
      rd_mux = period_q;
    end else if (paddr_i == ptcb_pkg::OFS_CTRL) begin
      rd_mux = ctrl_q;
    end else if (paddr_i == ptcb_pkg::OFS_STATE) begin
      rd_mux = state_word(gen_q);
    end else if (paddr_i == ptcb_pkg::OFS_STEPS) begin
      rd_mux = {{(32-CNT_W){1'b0}}, steps_q};
    end else if (paddr_i == ptcb_pkg::OFS_PWIDTH) begin
      rd_mux = pw_q;
    end else if (paddr_i == ptcb_pkg::OFS_DIR) begin
      rd_mux = {28'h000_0000, dir_q};
    end
  end

  // apb handshake: one wait state, then the answer stands one cycle
  // writes to read-only words are dropped without an error
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= ptcb_pkg::RST_WORD;
    end else if (ce_i) begin
      if (acc_phase && !pready_q) begin
        pready_q  <= 1'b1;
        pslverr_q <= !mapped;
        prdata_q  <= mapped ? rd_mux : ptcb_pkg::RST_WORD;
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      period_q <= ptcb_pkg::RST_WORD;
    end else if (ce_i && wr_en && paddr_i == ptcb_pkg::OFS_PERIOD) begin
      period_q <= pwdata_i;
    end
  end

  // accept raises no interrupt or dma request; software
  // must poll the control word to feed the next command
  // hardware clear on accept; a host write in the same cycle wins
  assign hw_clr = (fsm_q == S_EVAL) && work_q.flag[0];

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_q <= ptcb_pkg::RST_WORD;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata_i;
      end else if (hw_clr) begin
        ctrl_q <= ptcb_pkg::RST_WORD;
      end
    end
  end

  // one step costs about 34 cycles of division; a pulse finishing
  // sooner is only taken in the wait state, so the train slows down
  // rather than publishing a width that is not yet computed
  // restoring divider step, unsigned truncating
  assign rem_sh = {rem_q, num_q[31]};
  // round by adding one then halving
  assign delta  = (quo_q + 32'h0000_0001) >> 1;

  // main sequencer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fsm_q     <= S_RESET;
      work_q    <= '0;
      steps_q   <= '0;
      pw_q      <= ptcb_pkg::RST_WORD;
      dir_q     <= ptcb_pkg::DIR_DELAY;
      acc_q     <= ptcb_pkg::ACC_CONST;
      den_q     <= '0;
      quo_q     <= ptcb_pkg::RST_WORD;
      rem_q     <= ptcb_pkg::RST_WORD;
      num_q     <= ptcb_pkg::RST_WORD;
      div_cnt_q <= '0;
    end else if (ce_i) begin
      case (fsm_q)
        S_RESET: begin
          // leave reset only on the idle code
          if (wr_en && paddr_i == ptcb_pkg::OFS_STATE &&
              pwdata_i == ptcb_pkg::ST_W_IDLE) begin
            fsm_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          // a pending command wakes the generator by itself
          // a zero-count command is accepted too: no step, buffer re-read
          if (ctrl_q[ptcb_pkg::FLAG_LSB]) begin
            fsm_q <= S_EVAL;
            // copy period and control into working holders
            pw_q   <= period_q;
            work_q <= ctrl_q;
          end
        end
        S_CHECK: begin
          // count down, or go back to the buffer at zero
          if (steps_q != '0) begin
            steps_q <= steps_q - 1'b1;
            if (acc_q == ptcb_pkg::ACC_CONST) begin
              fsm_q <= S_WAIT;
            end else begin
              // numerator four times previous width
              // the top two width bits are lost, so widths must stay
              // below 2^30 for the ramp to be exact
              num_q     <= {pw_q[29:0], 2'b00};
              rem_q     <= ptcb_pkg::RST_WORD;
              quo_q     <= ptcb_pkg::RST_WORD;
              div_cnt_q <= 6'(ptcb_pkg::DIV_CYCLES);
              fsm_q     <= S_DIV;
            end
          end else begin
            fsm_q  <= S_EVAL;
            pw_q   <= period_q;
            work_q <= ctrl_q;
          end
        end
        S_EVAL: begin
          // no flag, previous command done, go idle
          if (!work_q.flag[0]) begin
            fsm_q <= S_IDLE;
          end else begin
            // fields taken by position from the control layout
            // decode from the private copy only
            // load step counter and direction holder
            steps_q <= work_q.count[CNT_W-1:0];
            dir_q   <= work_q.dir;
            acc_q   <= work_q.acc;
            case (work_q.acc)
              ptcb_pkg::ACC_UP: begin
                den_q <= ptcb_pkg::DEN_ACC_SEED;
              end
              ptcb_pkg::ACC_DEC: begin
                den_q <= dec_seed(work_q.count[CNT_W-1:0]);
              end
              default: begin
                den_q <= '0;
              end
            endcase
            fsm_q <= S_CHECK;
          end
        end
        S_DIV: begin
          // a non-positive denominator leaves the width unchanged
          if (den_q <= 0) begin
            fsm_q <= S_WAIT;
          end else if (div_cnt_q != '0) begin
            num_q     <= {num_q[30:0], 1'b0};
            div_cnt_q <= div_cnt_q - 1'b1;
            if (rem_sh >= {1'b0, den_q}) begin
              rem_q <= 32'(rem_sh - {1'b0, den_q});
              quo_q <= {quo_q[30:0], 1'b1};
            end else begin
              rem_q <= rem_sh[31:0];
              quo_q <= {quo_q[30:0], 1'b0};
            end
          end else begin
            // accelerate shortens, decelerate lengthens
            // floor of one keeps the step logic from a zero-length pulse
            if (acc_q == ptcb_pkg::ACC_UP) begin
              pw_q  <= (delta < pw_q) ? pw_q - delta : 32'h0000_0001;
              den_q <= den_q + ptcb_pkg::DEN_STEP;
            end else begin
              pw_q  <= pw_q + delta;
              den_q <= den_q - ptcb_pkg::DEN_STEP;
            end
            fsm_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // step logic reports the current pulse finished
          // done of the previous pulse is still held while the new start
          // pulse stands (constant speed gets here at once), so it is
          // not believed in that cycle or steps would run back to back
          if (step_done_i && !step_start_q) begin
            fsm_q <= S_CHECK;
          end
        end
        default: begin
          fsm_q <= S_RESET;
        end
      endcase
    end
  end

  // step request and published width; width sampled before update
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      step_start_q <= 1'b0;
      pulse_q      <= '0;
    end else if (ce_i) begin
      step_start_q <= 1'b0;
      // outside a step the published values simply hold
      if (fsm_q == S_CHECK && steps_q != '0) begin
        // direction code passed through unchanged
        // step logic maps 1, f and 0 to forward, reverse and delay
        step_start_q  <= 1'b1;
        pulse_q.width <= pw_q;
        pulse_q.dir   <= dir_q;
      end
    end
  end

  // generator state follows the sequencer
  // it lags the sequencer by one cycle; the state word read and the
  // state output both come from here, so they always agree
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gen_q <= ptcb_pkg::GEN_RESET;
    end else if (ce_i) begin
      if (fsm_q == S_RESET) begin
        gen_q <= ptcb_pkg::GEN_RESET;
      end else if (fsm_q == S_IDLE) begin
        gen_q <= ptcb_pkg::GEN_IDLE;
      end else begin
        gen_q <= ptcb_pkg::GEN_ACTIVE;
      end
    end
  end

  assign prdata_o     = prdata_q;
  assign pready_o     = pready_q;
  assign pslverr_o    = pslverr_q;
  assign step_start_o = step_start_q;
  assign pulse_o      = pulse_q;
  assign gen_state_o  = gen_q;

endmodule

// ===== rtl/ptcb_pkg.sv
package ptcb_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_PERIOD = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STATE  = 8'h08;
  localparam logic [7:0] OFS_STEPS  = 8'h0c;
  localparam logic [7:0] OFS_PWIDTH = 8'h10;
  localparam logic [7:0] OFS_DIR    = 8'h14;

  // reset values and state word codes
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [31:0] ST_W_RST  = 32'h0000_0000;
  localparam logic [31:0] ST_W_IDLE = 32'h4000_0000;
  localparam logic [31:0] ST_W_ACT  = 32'h8000_0000;

  // control word field positions
  localparam int FLAG_LSB = 28;
  localparam int DIR_LSB  = 24;
  localparam int ACC_LSB  = 22;
  localparam int CNT_W    = 20;

  // direction codes
  localparam logic [3:0] DIR_FWD   = 4'h1;
  localparam logic [3:0] DIR_REV   = 4'hf;
  localparam logic [3:0] DIR_DELAY = 4'h0;

  // acceleration codes
  localparam logic [1:0] ACC_DEC   = 2'h3;
  localparam logic [1:0] ACC_UP    = 2'h2;
  localparam logic [1:0] ACC_CONST = 2'h0;

  // denominator seeds and step
  localparam logic [31:0] DEN_ACC_SEED = 32'h0000_0005;
  localparam logic [31:0] DEN_DEC_OFS  = 32'h0000_0005;
  localparam logic [31:0] DEN_STEP     = 32'h0000_0004;
  localparam int          DIV_CYCLES   = 32;

  typedef struct packed {
    logic [3:0]       flag;
    logic [3:0]       dir;
    logic [1:0]       acc;
    logic [1:0]       rsvd;
    logic [CNT_W-1:0] count;
  } ptcb_ctrl_s;

  typedef struct packed {
    logic [31:0] width;
    logic [3:0]  dir;
  } ptcb_pulse_s;

  typedef enum logic [1:0] {
    GEN_RESET,
    GEN_IDLE,
    GEN_ACTIVE
  } ptcb_gen_e;

endpackage

// ===== verification/ptcb_step_model.sv
`timescale 1ns/1ps

module ptcb_step_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // generator side
  input  wire logic       step_start_i,
  input  wire logic [1:0] gen_state_i,
  output logic            step_done_o
);
  logic busy_q;
  int   wait_q;

  // step finish
  // done is held until the next step or idle acknowledges it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      step_done_o <= 1'b0;
      busy_q      <= 1'b0;
      wait_q      <= 0;
    end else if (step_start_i) begin
      step_done_o <= 1'b0;
      busy_q      <= 1'b1;
      wait_q      <= $urandom_range(60, 1);
    end else if (gen_state_i == ptcb_pkg::GEN_IDLE) begin
      step_done_o <= 1'b0;
    end else if (busy_q && wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (busy_q) begin
      step_done_o <= 1'b1;
      busy_q      <= 1'b0;
    end
  end
endmodule

// ===== verification/ptcb_monitor.sv
`timescale 1ns/1ps

module ptcb_monitor #(
  parameter int CNT_W = 20
) (
  // clock, reset, enable
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        ce_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // step side
  input wire logic        step_done_i,
  input wire logic        step_start_o,
  input wire ptcb_pkg::ptcb_pulse_s pulse_o,
  input wire logic [1:0]  gen_state_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  logic st_wr;
  logic ctl_wr;
  assign st_wr  = ce_i && pready_o && pwrite_i && !pslverr_o && paddr_i == ptcb_pkg::OFS_STATE
                  && pwdata_i == ptcb_pkg::ST_W_IDLE;
  assign ctl_wr = ce_i && pready_o && pwrite_i && paddr_i == ptcb_pkg::OFS_CTRL
                  && pwdata_i[28] && pwdata_i[19:0] != 20'h0;

  property p_wait;
    $past(psel_i && !penable_i) && psel_i && penable_i && ce_i |-> !pready_o ##1 pready_o;
  endproperty
  property p_one;
    pready_o |=> !pready_o;
  endproperty
  property p_err;
    pready_o && paddr_i > 8'h14 |-> pslverr_o && prdata_o == 32'h0;
  endproperty
  property p_rst_hold;
    gen_state_o == ptcb_pkg::GEN_RESET && !st_wr && !$past(st_wr)
      |=> gen_state_o == ptcb_pkg::GEN_RESET;
  endproperty
  property p_to_idle;
    gen_state_o == ptcb_pkg::GEN_RESET && st_wr |=> ##1 gen_state_o == ptcb_pkg::GEN_IDLE;
  endproperty
  property p_quiet;
    gen_state_o != ptcb_pkg::GEN_ACTIVE |-> !step_start_o;
  endproperty
  property p_hold;
    !step_start_o |-> $stable(pulse_o);
  endproperty
  property p_start;
    gen_state_o == ptcb_pkg::GEN_IDLE && ctl_wr |-> ##[1:10] step_start_o;
  endproperty
  property p_gap;
    step_start_o |=> !step_start_o [*3];
  endproperty

  a_wait: assert property (p_wait) else $error("apb answer not after one wait");
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_rst_hold: assert property (p_rst_hold) else $error("left reset state");
  a_to_idle: assert property (p_to_idle) else $error("idle code not taken");
  a_quiet: assert property (p_quiet) else $error("step outside active");
  a_hold: assert property (p_hold) else $error("pulse changed between steps");
  a_start: assert property (p_start) else $error("command did not start");
  a_gap: assert property (p_gap) else $error("steps too close");

  c_step: cover property (step_start_o);
  c_err: cover property (pslverr_o);
  c_back: cover property (gen_state_o == ptcb_pkg::GEN_IDLE && $past(step_start_o, 1) == 1'b0);
endmodule

bind ptcb_top ptcb_monitor #(.CNT_W(CNT_W)) i_mon (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .step_done_i(step_done_i), .step_start_o(step_start_o), .pulse_o(pulse_o),
  .gen_state_o(gen_state_o)
);

// ===== verification/tb.sv
`timescale 1ns/1ps

module tb;
  logic                  clock_i;
  logic                  sys_rst_i;
  logic                  ce_i;
  logic                  psel_i;
  logic                  penable_i;
  logic                  pwrite_i;
  logic [7:0]            paddr_i;
  logic [31:0]           pwdata_i;
  logic [31:0]           prdata_o;
  logic                  pready_o;
  logic                  pslverr_o;
  logic                  step_done_i;
  logic                  step_start_o;
  logic [1:0]            gen_state_o;
  ptcb_pkg::ptcb_pulse_s pulse_o;
  int                    bad_count;
  int                    compares;
  logic [31:0]           rd;
  logic                  err;
  logic [31:0]           per [3];
  int                    cnt [3];
  logic [3:0]            dirs [3];
  logic [1:0]            accs [3];

  ptcb_top i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .step_done_i(step_done_i), .step_start_o(step_start_o), .pulse_o(pulse_o),
    .gen_state_o(gen_state_o)
  );

  ptcb_step_model i_far (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .step_start_i(step_start_o),
    .gen_state_i(gen_state_o), .step_done_o(step_done_i)
  );

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task hang();
    bad_count++;
    stop_test();
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) hang();
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task send(input int i);
    int n;
    n = 0;
    do begin
      apb(1'b0, ptcb_pkg::OFS_CTRL, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 200);
    if (rd !== 32'h0) hang();
    apb(1'b1, ptcb_pkg::OFS_PERIOD, per[i]);
    apb(1'b1, ptcb_pkg::OFS_CTRL, {4'h1, dirs[i], accs[i], 2'h0, 20'(cnt[i])});
  endtask

  function automatic logic [31:0] nxt(logic [31:0] w, logic [1:0] acc, int m, int i);
    int          den;
    logic [31:0] r;
    den = (acc == ptcb_pkg::ACC_UP) ? 4 * i + 1 : 4 * m - 1 - 4 * i;
    if (!(acc inside {ptcb_pkg::ACC_UP, ptcb_pkg::ACC_DEC}) || den <= 0) return w;
    r = ((w * 4) / 32'(den) + 1) / 2;
    return (acc == ptcb_pkg::ACC_DEC) ? w + r : (w > r ? w - r : 32'h1);
  endfunction

  task run(input int i);
    logic [31:0] w;
    int          n;
    w = per[i];
    for (int k = 1; k <= cnt[i]; k++) begin
      n = 0;
      do begin
        @(posedge clock_i);
        n++;
      end while (step_start_o !== 1'b1 && n < 3000);
      if (step_start_o !== 1'b1) hang();
      chk(pulse_o.width, w);
      chk(32'(pulse_o.dir), 32'(dirs[i]));
      w = nxt(w, accs[i], cnt[i], k);
    end
    $display("test run %0d done", i);
  endtask

  initial begin
    int n;
    sys_rst_i = 1'b1;
    ce_i      = 1'b1;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 8'h00;
    pwdata_i  = 32'h0;
    bad_count = 0;
    compares  = 0;
    void'($urandom(32'h5f68));
    for (int i = 0; i < 3; i++) begin
      per[i] = 32'd1000 + $urandom_range(60000);
      cnt[i] = $urandom_range(4, 3);
    end
    dirs = '{ptcb_pkg::DIR_FWD, ptcb_pkg::DIR_REV, ptcb_pkg::DIR_DELAY};
    accs = '{ptcb_pkg::ACC_UP, ptcb_pkg::ACC_DEC, ptcb_pkg::ACC_CONST};
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    apb(1'b1, ptcb_pkg::OFS_STATE, ptcb_pkg::ST_W_ACT);
    apb(1'b0, ptcb_pkg::OFS_STATE, 32'h0);
    chk(rd, ptcb_pkg::ST_W_RST);
    apb(1'b1, 8'h40, 32'h5a5a);
    chk(32'(err), 32'h1);
    apb(1'b1, ptcb_pkg::OFS_STATE, ptcb_pkg::ST_W_IDLE);
    apb(1'b0, ptcb_pkg::OFS_STATE, 32'h0);
    chk(rd, ptcb_pkg::ST_W_IDLE);
    apb(1'b1, ptcb_pkg::OFS_PERIOD, per[2]);
    apb(1'b0, ptcb_pkg::OFS_PERIOD, 32'h0);
    chk(rd, per[2]);
    $display("test regs done");
    // second command queued while the first steps
    send(0);
    fork
      send(1);
      run(0);
    join
    run(1);
    send(2);
    run(2);
    apb(1'b0, ptcb_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ptcb_pkg::OFS_DIR, 32'h0);
    chk(rd, 32'(ptcb_pkg::DIR_DELAY));
    apb(1'b0, ptcb_pkg::OFS_PWIDTH, 32'h0);
    chk(rd, per[2]);
    n = 0;
    while (gen_state_o !== ptcb_pkg::GEN_IDLE && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    if (gen_state_o !== ptcb_pkg::GEN_IDLE) hang();
    apb(1'b0, ptcb_pkg::OFS_STATE, 32'h0);
    chk(rd, ptcb_pkg::ST_W_IDLE);
    $display("test idle done");
    stop_test();
  end
endmodule
